// ### lgsm_assertions.sv
// checker: port relations of the led/gpio strap pin mux
`timescale 1ns/1ps
module lgsm_assertions (
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic PREADY,
    input wire logic [1:0] IND_ACTIVE,
    input wire logic [1:0] PIN_I,
    input wire logic [1:0] PIN_O,
    input wire logic [1:0] PIN_OE,
    input wire logic EEPROM_LARGE,
    input wire logic PORT1_INTERNAL_PHY_STRAP
);
    logic [31:0] ind_q, od_q, dd_q;
    logic [2:0] cnt_q;
    logic [1:0] st, en, dir, pp, od, lod, lpp;
    logic wr, live;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    // decoded views of the shadow registers
    assign wr = PSEL & PENABLE & PWRITE & PREADY;
    assign live = cnt_q == 3'h7;
    assign st = {EEPROM_LARGE, PORT1_INTERNAL_PHY_STRAP};
    assign en = ind_q[1:0];
    assign dir = ~en & dd_q[9:8];
    assign pp = dir & ~od_q[1:0];
    assign od = dir & od_q[1:0];
    assign lod = en & {2{ind_q[10:8] >= lgsm_pkg::FUNC_OD_MIN}};
    assign lpp = en & ~lod;
    // shadows; pins judged only well after the strap sample, margin over settle time
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            {ind_q, od_q, dd_q} <= '0;
            cnt_q <= 3'h0;
        end else begin
            cnt_q <= live ? cnt_q : cnt_q + 3'h1;
            if (wr && PADDR == lgsm_pkg::OFS_INDICATOR_CONFIG)
                ind_q <= PWDATA;
            if (wr && PADDR == lgsm_pkg::OFS_GEN_IO_CONFIG)
                od_q <= PWDATA;
            if (wr && PADDR == lgsm_pkg::OFS_GEN_IO_DATA_DIR)
                dd_q <= PWDATA;
        end
    end
    sequence s_settled;
        $rose(RST_B) ##0 (RST_B && $stable(PIN_I))[*8];
    endsequence
    a_eeprom_small: assert property (s_settled ##0 !PIN_I[1] |-> !EEPROM_LARGE)
        else $error("eeprom size not small");
    a_eeprom_large: assert property (s_settled ##0 PIN_I[1] |-> EEPROM_LARGE)
        else $error("eeprom size not large");
    a_phy_strap: assert property (s_settled |-> PORT1_INTERNAL_PHY_STRAP == PIN_I[0])
        else $error("phy strap not latched");
    sequence s_pins_off;
        PIN_OE == 2'h0 ##1 PIN_OE == 2'h0 ##1 PIN_OE == 2'h0;
    endsequence
    a_strap_quiet: assert property ($rose(RST_B) |-> s_pins_off)
        else $error("pin driven during strap sample");
    a_strap_held: assert property (live && $past(live) |-> $stable(st))
        else $error("latched straps moved");
    a_gio_push: assert property (
        live |-> (PIN_OE & pp) == pp && ((PIN_O ^ dd_q[1:0]) & pp) == 2'h0)
        else $error("push-pull io wrong");
    a_gio_drain: assert property (
        live |-> ((PIN_OE ^ ~dd_q[1:0]) & od) == 2'h0 && (PIN_O & PIN_OE & od) == 2'h0)
        else $error("open-drain io wrong");
    a_gio_input: assert property (live |-> (PIN_OE & ~en & ~dd_q[9:8]) == 2'h0)
        else $error("input pin driven");
    a_led_push: assert property (live |-> (PIN_OE & lpp) == lpp)
        else $error("push-pull indicator not driven");
    a_led_drain: assert property (
        live && $stable(IND_ACTIVE) |-> ((PIN_OE ^ IND_ACTIVE) & lod) == 2'h0
            && ((PIN_O ^ st) & PIN_OE & lod) == 2'h0)
        else $error("open-drain indicator wrong");
endmodule // lgsm_assertions
bind lgsm_top lgsm_assertions lgsm_assertions_inst (.MCLK, .RST_B, .PSEL, .PENABLE, .PWRITE,
    .PADDR, .PWDATA, .PREADY, .IND_ACTIVE, .PIN_I, .PIN_O, .PIN_OE, .EEPROM_LARGE,
    .PORT1_INTERNAL_PHY_STRAP);

// ### lgsm_board.sv
// board model: strap resistors and the level seen at each shared pin
`timescale 1ns/1ps
module lgsm_board (
    input wire logic [1:0] strap,
    input wire logic [1:0] pin_o,
    input wire logic [1:0] pin_oe,
    output logic [1:0] pin_i
);
    // a released pin floats to its strap resistor level
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & strap);
endmodule // lgsm_board

// ### lgsm_pin.sv
// one shared pin: indicator or general io output buffer selection
`timescale 1ns/1ps
module lgsm_pin (
    input wire logic led_en,
    input wire logic led_od,
    input wire logic led_pol,
    input wire logic led_on,
    input wire logic gio_dir_out,
    input wire logic gio_od,
    input wire logic gio_data,
    input wire logic strap_hold,
    output logic pin_o,
    output logic pin_oe
);
    // pin stays undriven while straps are being sampled
    always_comb begin
        pin_o = 1'b0;
        pin_oe = 1'b0;
        if (strap_hold) begin
            pin_o = 1'b0;
            pin_oe = 1'b0;
        end else if (led_en) begin
            if (led_od) begin
                // active level follows strap: drive only when asserted
                pin_o = led_pol;
                pin_oe = led_on;
            end else begin
                pin_o = led_on;
                pin_oe = 1'b1;
            end
        end else if (gio_dir_out) begin
            if (gio_od) begin
                pin_o = 1'b0;
                pin_oe = ~gio_data;
            end else begin
                pin_o = gio_data;
                pin_oe = 1'b1;
            end
        end
    end
endmodule // lgsm_pin

// ### lgsm_pkg.sv
// package: register map, field layout and reset values for the led/gpio strap pin mux
package lgsm_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_INDICATOR_CONFIG = 8'h00;
    localparam logic [7:0] OFS_GEN_IO_CONFIG = 8'h04;
    localparam logic [7:0] OFS_GEN_IO_DATA_DIR = 8'h08;
    localparam logic [7:0] OFS_STRAP_STATUS = 8'h0C;
    // indicator config fields
    localparam int IND_EN_ONE_BIT = 0;
    localparam int IND_EN_TWO_BIT = 1;
    localparam int IND_FUNC_LSB = 8;
    localparam int IND_FUNC_W = 3;
    // gen io config: per pin open-drain select
    localparam int GIO_OD_LSB = 0;
    // data/dir: data bits [1:0], direction bits [9:8] (1 = output), input bits [17:16]
    localparam int GIO_DATA_LSB = 0;
    localparam int GIO_DIR_LSB = 8;
    localparam int GIO_IN_LSB = 16;
    // strap status fields
    localparam int ST_EEPROM_BIT = 0;
    localparam int ST_PHY_BIT = 1;
    localparam int ST_LARGE_BIT = 2;
    // reset values
    localparam logic [31:0] RST_INDICATOR_CONFIG = 32'h0000_0000;
    localparam logic [31:0] RST_GEN_IO_CONFIG = 32'h0000_0000;
    localparam logic [31:0] RST_GEN_IO_DATA_DIR = 32'h0000_0000;
    // function codes at or above this use the open-drain/open-source buffer
    localparam logic [2:0] FUNC_OD_MIN = 3'h4;
    // strap straps are pulled up; value seen before the first sample
    localparam logic STRAP_RST_VAL = 1'b1;
    // cycles after reset release before the strap sample is taken
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
endpackage

// ### lgsm_top.sv
// top: apb registers, strap latch and two shared indicator/general-io pins
// Overview of operation
// - led enable set drives the pin with its indicator function
// - three-bit function field picks push-pull or open-drain/open-source buffer
// - open-drain indicator polarity follows that pin's latched strap
// - led enable clear makes the pin a general io
// - general io is push-pull out, open-drain out or schmitt input
// - eeprom strap low selects 1K to 16K bit eeprom range
// - eeprom strap high selects 32K to 512K bit eeprom range
// - latched port 1 phy strap feeds port 0 and 1 mode selection
// - straps latch at power-on and at external reset release
`timescale 1ns/1ps
module lgsm_top (
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [1:0] IND_ACTIVE,
    input wire logic [1:0] PIN_I,
    output logic [1:0] PIN_O,
    output logic [1:0] PIN_OE,
    output logic EEPROM_LARGE,
    output logic PORT1_INTERNAL_PHY_STRAP
);
    // timing after reset release, in clock edges:
    //   edges 1 to 3: pins released, strap resistors settle through the synchroniser
    //   edge 4: straps taken from the second synchroniser flop, pins handed back
    //   later: latched straps move only on the next reset, whatever the board does
    // apb: zero wait states; read data is staged in the setup cycle
    // limitation: a pad level read over apb lags the pin by three edges

    // strap capture phases; settle keeps both pins released
    typedef enum {LGSM_SETTLE, LGSM_RUN} lgsm_strap_e;

    // two-flop synchronisers for the pad inputs
    logic [1:0] sync1_q, sync1_d;
    logic [1:0] sync2_q, sync2_d;
    // registers
    logic [31:0] ind_cfg_q, ind_cfg_d;
    logic [31:0] gio_cfg_q, gio_cfg_d;
    logic [31:0] gio_dd_q, gio_dd_d;
    logic [31:0] prdata_q, prdata_d;
    // strap capture
    logic [1:0] strap_q, strap_d;
    logic [1:0] settle_q, settle_d;
    lgsm_strap_e phase_q, phase_d;
    logic hold;
    logic [1:0] led_en, gio_od, gio_dir, gio_dat, led_pol;
    logic led_od;
    logic wr_en, rd_en, addr_ok;
    logic sel_ind, sel_gio, sel_dd, sel_st;
    logic [31:0] dd_word, strap_word;

    // pad sampling; first flop only feeds the second
    always_comb begin
        sync1_d = PIN_I;
        sync2_d = sync1_q;
    end

    always_ff @(posedge MCLK) begin
        sync1_q <= sync1_d;
        sync2_q <= sync2_d;
    end

    // strap window: pins released, pull-ups settle, then one sample
    always_comb begin
        settle_d = settle_q;
        phase_d = phase_q;
        strap_d = strap_q;
        hold = 1'b0;
        case (phase_q)
            LGSM_SETTLE: begin
                hold = 1'b1;
                if (settle_q == lgsm_pkg::STRAP_SETTLE) begin
                    strap_d = sync2_q;
                    phase_d = LGSM_RUN; // straps frozen from here on
                end else begin
                    settle_d = settle_q + 2'h1;
                end
            end
            LGSM_RUN: begin
                // nothing moves the straps until the next reset
                phase_d = LGSM_RUN;
            end
            default: begin
                // an unknown phase falls back to settle without clearing the settle count
                phase_d = LGSM_SETTLE;
            end
        endcase
    end

    // reset covers both power-on and the external pin; both rearm the sample
    // power-on is expected to arrive as RST_B low as well
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            settle_q <= 2'h0;
            phase_q <= LGSM_SETTLE;
            strap_q <= {2{lgsm_pkg::STRAP_RST_VAL}};
        end else begin
            settle_q <= settle_d;
            phase_q <= phase_d;
            strap_q <= strap_d;
        end
    end

    // pin 0 is indicator one (phy strap), pin 1 is indicator two (eeprom strap)
    always_comb begin
        EEPROM_LARGE = strap_q[1]; // low: small range, high: large range
        PORT1_INTERNAL_PHY_STRAP = strap_q[0]; // to port mode decode
    end

    // apb decode: zero wait states, unmapped reads zero and flag an error
    // one select per register feeds the error flag; the read and write maps decode PADDR on their own
    always_comb begin
        sel_ind = (PADDR == lgsm_pkg::OFS_INDICATOR_CONFIG);
        sel_gio = (PADDR == lgsm_pkg::OFS_GEN_IO_CONFIG);
        sel_dd = (PADDR == lgsm_pkg::OFS_GEN_IO_DATA_DIR);
        sel_st = (PADDR == lgsm_pkg::OFS_STRAP_STATUS);
        addr_ok = sel_ind || sel_gio || sel_dd || sel_st;
        wr_en = PSEL && PENABLE && PWRITE;
        rd_en = PSEL && !PENABLE && !PWRITE;
        PREADY = 1'b1;
        PSLVERR = PSEL && PENABLE && !addr_ok;
        PRDATA = prdata_q;
    end

    // read views that mix live state into a register word
    always_comb begin
        dd_word = gio_dd_q;
        dd_word[lgsm_pkg::GIO_IN_LSB +: 2] = sync2_q; // schmitt input
        strap_word = 32'h0000_0000;
        strap_word[lgsm_pkg::ST_EEPROM_BIT] = strap_q[1];
        strap_word[lgsm_pkg::ST_PHY_BIT] = strap_q[0];
        strap_word[lgsm_pkg::ST_LARGE_BIT] = strap_q[1]; // set means the large range
    end

    // register writes; the strap status word has no write path
    always_comb begin
        ind_cfg_d = ind_cfg_q;
        gio_cfg_d = gio_cfg_q;
        gio_dd_d = gio_dd_q;
        if (wr_en) begin
            case (PADDR)
                lgsm_pkg::OFS_INDICATOR_CONFIG: ind_cfg_d = PWDATA;
                lgsm_pkg::OFS_GEN_IO_CONFIG: gio_cfg_d = PWDATA;
                lgsm_pkg::OFS_GEN_IO_DATA_DIR: gio_dd_d = PWDATA;
                default: ;
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            ind_cfg_q <= lgsm_pkg::RST_INDICATOR_CONFIG;
            gio_cfg_q <= lgsm_pkg::RST_GEN_IO_CONFIG;
            gio_dd_q <= lgsm_pkg::RST_GEN_IO_DATA_DIR;
        end else begin
            ind_cfg_q <= ind_cfg_d;
            gio_cfg_q <= gio_cfg_d;
            gio_dd_q <= gio_dd_d;
        end
    end

    // read data staged in the setup cycle so PRDATA comes from a flop
    always_comb begin
        prdata_d = prdata_q;
        if (rd_en) begin
            case (PADDR)
                lgsm_pkg::OFS_INDICATOR_CONFIG: prdata_d = ind_cfg_q;
                lgsm_pkg::OFS_GEN_IO_CONFIG: prdata_d = gio_cfg_q;
                lgsm_pkg::OFS_GEN_IO_DATA_DIR: prdata_d = dd_word;
                lgsm_pkg::OFS_STRAP_STATUS: prdata_d = strap_word;
                default: prdata_d = 32'h0000_0000;
            endcase
        end
    end

    // held until the next read setup, so a slow master still sees it
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            prdata_q <= 32'h0000_0000;
        end else begin
            prdata_q <= prdata_d;
        end
    end

    // field extraction shared by both pins
    // one function field serves both pins, so their buffer type always matches
    always_comb begin
        led_en[0] = ind_cfg_q[lgsm_pkg::IND_EN_ONE_BIT];
        led_en[1] = ind_cfg_q[lgsm_pkg::IND_EN_TWO_BIT];
        led_od = ind_cfg_q[lgsm_pkg::IND_FUNC_LSB +: lgsm_pkg::IND_FUNC_W]
                 >= lgsm_pkg::FUNC_OD_MIN;
        gio_od = gio_cfg_q[lgsm_pkg::GIO_OD_LSB +: 2];
        gio_dir = gio_dd_q[lgsm_pkg::GIO_DIR_LSB +: 2];
        gio_dat = gio_dd_q[lgsm_pkg::GIO_DATA_LSB +: 2];
        led_pol = strap_q;
    end

    // one output stage per shared pin
    for (genvar i = 0; i < 2; i++) begin : g_pin
        lgsm_pin u_pin (
            .led_en(led_en[i]),
            .led_od(led_od),
            .led_pol(led_pol[i]),
            .led_on(IND_ACTIVE[i]),
            .gio_dir_out(gio_dir[i]),
            .gio_od(gio_od[i]),
            .gio_data(gio_dat[i]),
            .strap_hold(hold),
            .pin_o(PIN_O[i]),
            .pin_oe(PIN_OE[i])
        );
    end
endmodule // lgsm_top

// ### lgsm_top_bench.sv
// bench: straps, general io and indicator modes of the pin mux
`timescale 1ns/1ps
module lgsm_top_bench;
    logic MCLK = 1'h0, RST_B = 1'h0, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA;
    logic [1:0] IND_ACTIVE = 2'h0, PIN_I, PIN_O, PIN_OE, strap = 2'h3;
    logic PREADY, EEPROM_LARGE, PORT1_INTERNAL_PHY_STRAP, PSLVERR, slv_err;
    int fail_count = 0, samples_checked = 0;
    lgsm_top lgsm_top_inst (.MCLK, .RST_B, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
        .PREADY, .PSLVERR, .IND_ACTIVE, .PIN_I, .PIN_O, .PIN_OE, .EEPROM_LARGE,
        .PORT1_INTERNAL_PHY_STRAP);
    lgsm_board lgsm_board_inst (.strap, .pin_o(PIN_O), .pin_oe(PIN_OE), .pin_i(PIN_I));
    always #2.5 MCLK = ~MCLK;
    // run is under two hundred cycles; far beyond that means a hang
    initial begin
        #20000;
        fail_count++;
        stop_test();
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one apb transfer; held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        PSEL <= 1'h1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'h1;
        do @(posedge MCLK); while (PREADY !== 1'h1);
        r = PRDATA;
        slv_err = PSLVERR;
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
        // idle cycle, so a following call never re-raises psel in this step
        @(posedge MCLK);
    endtask
    task automatic do_reset(input logic [1:0] s);
        strap <= s;
        RST_B <= 1'h0;
        repeat (10) @(posedge MCLK);
        RST_B <= 1'h1;
        repeat (12) @(posedge MCLK);
    endtask
    // every strap pattern, then a board change after the latch
    task automatic t_straps;
        logic [31:0] r;
        for (int s = 0; s < 4; s++) begin
            do_reset(s[1:0]);
            apb(1'h0, lgsm_pkg::OFS_STRAP_STATUS, 32'h0, r);
            chk("strap status", {29'h0, s[1], s[0], s[1]}, r);
            strap <= ~s[1:0];
            repeat (4) @(posedge MCLK);
            chk("eeprom large", s[1], EEPROM_LARGE);
            chk("phy strap", s[0], PORT1_INTERNAL_PHY_STRAP);
        end
    endtask
    // general io as push-pull, open-drain, then input
    task automatic t_gpio;
        logic [31:0] r;
        apb(1'h1, lgsm_pkg::OFS_GEN_IO_DATA_DIR, 32'h0000_0301, r);
        @(posedge MCLK);
        chk("pp pins", 32'hD, {PIN_OE, PIN_O});
        apb(1'h1, lgsm_pkg::OFS_GEN_IO_CONFIG, 32'h3, r);
        @(posedge MCLK);
        chk("od pins", 32'h4, {PIN_OE, PIN_O[1]});
        strap <= 2'h2;
        apb(1'h1, lgsm_pkg::OFS_GEN_IO_DATA_DIR, 32'h0, r);
        // released pad level needs the synchroniser plus the read staging flop
        repeat (2) @(posedge MCLK);
        apb(1'h0, lgsm_pkg::OFS_GEN_IO_DATA_DIR, 32'h0, r);
        chk("input pins", 32'h0002_0000, r);
        chk("mapped err", 32'h0, slv_err);
        chk("input oe", 32'h0, PIN_OE);
        apb(1'h0, 8'h10, 32'h0, r);
        chk("unmapped", 32'h0, r);
        chk("unmapped err", 32'h1, slv_err);
    endtask
    // straps 01 give the two pins opposite polarity: open-drain function 4, then push-pull 3
    task automatic t_led;
        logic [31:0] r;
        do_reset(2'h1);
        IND_ACTIVE <= 2'h1;
        apb(1'h1, lgsm_pkg::OFS_INDICATOR_CONFIG, 32'h0000_0403, r);
        @(posedge MCLK);
        chk("od led", 32'h5, {PIN_OE, PIN_O});
        IND_ACTIVE <= 2'h2;
        @(posedge MCLK);
        chk("od led two", 32'h9, {PIN_OE, PIN_O});
        apb(1'h1, lgsm_pkg::OFS_INDICATOR_CONFIG, 32'h0000_0301, r);
        @(posedge MCLK);
        chk("pp led", 32'h2, {PIN_OE, PIN_O[0]});
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        t_straps();
        t_gpio();
        t_led();
        stop_test();
    end
endmodule // lgsm_top_bench
